// File: common/cis_pkg.sv
/*
 * Shared constants for the core interrupt sequencer: vector layout, status bit
 * positions, cycle counts and the register map of the software port.
 * Assumes a single-clock core with a 16-bit program counter and stack pointer.
 */
package cis_pkg;
    localparam int          NUM_SRC_DEF     = 8;
    localparam int          PC_W            = 16;
    localparam int          SP_W            = 16;
    localparam int          ADDR_W          = 4;
    localparam int          DATA_W          = 8;
    localparam logic [15:0] VEC_BASE_APP    = 16'h0000;
    localparam logic [15:0] VEC_BASE_BOOT   = 16'h3800;
    localparam logic [15:0] VEC_SPACING     = 16'h0002;
    localparam int          GIE_BIT         = 7;
    localparam int          VSEL_BIT        = 1;
    localparam logic [7:0]  STATUS_RST      = 8'h00;
    localparam logic [7:0]  CTRL_RST        = 8'h00;
    localparam logic [15:0] SP_RST          = 16'h08ff;
    localparam logic [15:0] SP_STEP_CALL    = 16'h0002;
    // Entry, return, wake-up and vector-jump cycle counts.
    localparam logic [3:0]  ENTRY_CYC       = 4'h4;
    localparam logic [3:0]  WAKE_EXTRA_CYC  = 4'h4;
    localparam logic [3:0]  RETURN_CYC      = 4'h4;
    localparam logic [3:0]  JUMP_CYC        = 4'h3;
    localparam logic [3:0]  ONE_CYC         = 4'h1;
    // Register map of the software port.
    localparam logic [3:0]  REG_STATUS      = 4'h0;
    localparam logic [3:0]  REG_CTRL        = 4'h1;
    localparam logic [3:0]  REG_ENABLE      = 4'h2;
    localparam logic [3:0]  REG_FLAG        = 4'h3;
    localparam logic [3:0]  REG_SP_LO       = 4'h4;
    localparam logic [3:0]  REG_SP_HI       = 4'h5;
    localparam logic [3:0]  REG_LEVEL       = 4'h6;
    localparam logic [3:0]  REG_VEC_LO      = 4'h7;
    localparam logic [3:0]  REG_VEC_HI      = 4'h8;
    typedef enum logic [2:0] {
        CIS_RUN,
        CIS_ENTRY,
        CIS_RETURN,
        CIS_SHADOW
    } cis_state_t;
endpackage

// File: rtl/cpu_interrupt_sequencer.sv
/*
 * Reset and interrupt sequencer of an 8-bit core: picks the winning source,
 * gates it by the per-source and global enables, runs the entry and return
 * sequences, and tracks the program counter, stack pointer and global enable.
 * Assumes the instruction sequencer reports instruction boundaries, the
 * enable, disable and return instructions as one-cycle pulses, and that the
 * stack memory itself is written and read elsewhere from the addresses given.
 */
`timescale 1ns/1ps
module cpu_interrupt_sequencer #(
    parameter int NUM_SRC = cis_pkg::NUM_SRC_DEF
) (
    // Clock and reset.
    input  wire logic                      mclk,
    input  wire logic                      rst,
    // Straps and lock bits.
    input  wire logic                      bootResetFuse,
    input  wire logic                      appSectionLockBit,
    input  wire logic                      bootSectionLockBit,
    input  wire logic [cis_pkg::PC_W-1:0]  bootSectionStart,
    // Interrupt sources.
    input  wire logic [NUM_SRC-1:0]        srcEvent,
    input  wire logic [NUM_SRC-1:0]        srcLevel,
    // Instruction sequencer.
    input  wire logic                      instrDone,
    input  wire logic                      enableInstr,
    input  wire logic                      disableInstr,
    input  wire logic                      returnFromIrqInstr,
    input  wire logic                      sleeping,
    input  wire logic [cis_pkg::PC_W-1:0]  pcIn,
    input  wire logic [cis_pkg::PC_W-1:0]  popData,
    // Register port.
    input  wire logic [cis_pkg::ADDR_W-1:0] regAddr,
    input  wire logic [cis_pkg::DATA_W-1:0] regWdata,
    input  wire logic                      regWr,
    input  wire logic                      regRd,
    output logic [cis_pkg::DATA_W-1:0]     regRdata,
    // Sequencer outputs.
    output logic                           coreHold,
    output logic                           pcLoad,
    output logic [cis_pkg::PC_W-1:0]       pcLoadValue,
    output logic                           pushReq,
    output logic [cis_pkg::PC_W-1:0]       pushData,
    output logic [cis_pkg::SP_W-1:0]       stackPtr,
    output logic                           globalEnable,
    output logic                           inHandlerEntry
);
    localparam int IDX_W = (NUM_SRC > 1) ? $clog2(NUM_SRC) : 1;

    cis_pkg::cis_state_t              state_reg;
    logic [cis_pkg::DATA_W-1:0]       status_reg;
    logic [cis_pkg::DATA_W-1:0]       ctrl_reg;
    logic [NUM_SRC-1:0]               enable_reg;
    logic [NUM_SRC-1:0]               flag_reg;
    logic [NUM_SRC-1:0]               levelSel_reg;
    logic [cis_pkg::SP_W-1:0]         sp_reg;
    logic [3:0]                       cnt_reg;
    logic [IDX_W-1:0]                 win_reg;
    logic [cis_pkg::PC_W-1:0]         vec_reg;
    logic                             shadow_reg;
    logic                             started_reg;
    logic                             wakeEntry_reg;
    logic [NUM_SRC-1:0]               request;
    logic                             anyReq;
    logic [IDX_W-1:0]                 winIdx;
    logic                             lockBlock;
    logic                             acceptNow;
    logic [cis_pkg::PC_W-1:0]         vecBase;
    logic [NUM_SRC-1:0]               flagClr_next;
    logic [NUM_SRC-1:0]               flagSet;

    // Decodes a register-port write to the given offset.
    function automatic logic wrHit(input logic [3:0] a, input logic [3:0] off);
        return regWr && (a == off);
    endfunction

    // Latched sources use the flag; level sources use the live condition.
    assign flagSet = srcEvent & ~levelSel_reg;
    assign request = enable_reg & ((flag_reg & ~levelSel_reg) |
                                   (srcLevel & levelSel_reg));

    // Lowest index, hence lowest vector, wins.
    always_comb begin
        winIdx = '0;
        anyReq = 1'b0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (request[i]) begin
                winIdx = IDX_W'(i);
                anyReq = 1'b1;
            end
        end
    end

    // Lock bits block interrupts while the program counter sits in the locked section.
    assign lockBlock = (appSectionLockBit && (pcIn < bootSectionStart)) ||
                       (bootSectionLockBit && (pcIn >= bootSectionStart));

    assign vecBase = ctrl_reg[cis_pkg::VSEL_BIT] ? bootSectionStart
                                                 : cis_pkg::VEC_BASE_APP;

    // Disable in the same cycle wins; a shadow cycle after enable or return blocks.
    assign acceptNow = (state_reg == cis_pkg::CIS_RUN) && anyReq && instrDone &&
                       status_reg[cis_pkg::GIE_BIT] && !disableInstr &&
                       !shadow_reg && !lockBlock && started_reg;

    // One-hot clear of the winner on entry for latched sources.
    always_comb begin
        flagClr_next = '0;
        if (acceptNow && !levelSel_reg[winIdx]) begin
            flagClr_next[winIdx] = 1'b1;
        end
        if (wrHit(regAddr, cis_pkg::REG_FLAG)) begin
            flagClr_next = flagClr_next | regWdata[NUM_SRC-1:0];
        end
    end

    // Set wins over a clear in the same cycle.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            flag_reg <= '0;
        end else begin
            flag_reg <= (flag_reg & ~flagClr_next) | flagSet;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            enable_reg   <= '0;
            levelSel_reg <= '0;
            ctrl_reg     <= cis_pkg::CTRL_RST;
        end else begin
            if (wrHit(regAddr, cis_pkg::REG_ENABLE)) begin
                enable_reg <= regWdata[NUM_SRC-1:0];
            end
            if (wrHit(regAddr, cis_pkg::REG_LEVEL)) begin
                levelSel_reg <= regWdata[NUM_SRC-1:0];
            end
            if (wrHit(regAddr, cis_pkg::REG_CTRL)) begin
                ctrl_reg <= regWdata;
            end
        end
    end

    // Only the global enable is touched by hardware; other status bits are software's.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            status_reg <= cis_pkg::STATUS_RST;
        end else begin
            if (wrHit(regAddr, cis_pkg::REG_STATUS)) begin
                status_reg <= regWdata;
            end
            if (enableInstr) begin
                status_reg[cis_pkg::GIE_BIT] <= 1'b1;
            end
            if (disableInstr) begin
                status_reg[cis_pkg::GIE_BIT] <= 1'b0;
            end
            if (acceptNow) begin
                status_reg[cis_pkg::GIE_BIT] <= 1'b0;
            end
            if (state_reg == cis_pkg::CIS_RETURN && cnt_reg == cis_pkg::ONE_CYC) begin
                status_reg[cis_pkg::GIE_BIT] <= 1'b1;
            end
        end
    end

    // Blocks interrupts for the instruction following an enable or a return.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            shadow_reg <= 1'b0;
        end else if (enableInstr ||
                     (state_reg == cis_pkg::CIS_RETURN && cnt_reg == cis_pkg::ONE_CYC)) begin
            shadow_reg <= 1'b1;
        end else if (instrDone && state_reg == cis_pkg::CIS_RUN) begin
            shadow_reg <= 1'b0;
        end
    end

    // Sequence of entry and return.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg     <= cis_pkg::CIS_RUN;
            cnt_reg       <= '0;
            win_reg       <= '0;
            vec_reg       <= '0;
            wakeEntry_reg <= 1'b0;
        end else begin
            case (state_reg)
                cis_pkg::CIS_RUN: begin
                    if (acceptNow) begin
                        state_reg     <= cis_pkg::CIS_ENTRY;
                        win_reg       <= winIdx;
                        wakeEntry_reg <= sleeping;
                        cnt_reg       <= sleeping ? cis_pkg::ENTRY_CYC + cis_pkg::WAKE_EXTRA_CYC
                                                  : cis_pkg::ENTRY_CYC;
                        // Index 0 is reset, so source i sits at slot i + 1.
                        vec_reg       <= vecBase + cis_pkg::VEC_SPACING *
                                         (cis_pkg::PC_W'(winIdx) + 16'h0001);
                    end else if (returnFromIrqInstr) begin
                        state_reg <= cis_pkg::CIS_RETURN;
                        cnt_reg   <= cis_pkg::RETURN_CYC;
                    end
                end
                cis_pkg::CIS_ENTRY, cis_pkg::CIS_RETURN: begin
                    if (cnt_reg == cis_pkg::ONE_CYC) begin
                        state_reg <= cis_pkg::CIS_RUN;
                    end
                    cnt_reg <= cnt_reg - cis_pkg::ONE_CYC;
                end
                default: begin
                    state_reg <= cis_pkg::CIS_RUN;
                end
            endcase
        end
    end

    // Stack pointer: minus two on entry, plus two on return.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sp_reg <= cis_pkg::SP_RST;
        end else if (acceptNow) begin
            sp_reg <= sp_reg - cis_pkg::SP_STEP_CALL;
        end else if (state_reg == cis_pkg::CIS_RETURN && cnt_reg == cis_pkg::ONE_CYC) begin
            sp_reg <= sp_reg + cis_pkg::SP_STEP_CALL;
        end else if (wrHit(regAddr, cis_pkg::REG_SP_LO)) begin
            sp_reg[7:0] <= regWdata;
        end else if (wrHit(regAddr, cis_pkg::REG_SP_HI)) begin
            sp_reg[15:8] <= regWdata;
        end
    end

    // Start address after reset, then the program counter load pulses.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            started_reg <= 1'b0;
            pcLoad      <= 1'b0;
            pcLoadValue <= '0;
            pushReq     <= 1'b0;
            pushData    <= '0;
        end else begin
            pcLoad  <= 1'b0;
            pushReq <= 1'b0;
            if (!started_reg) begin
                started_reg <= 1'b1;
                pcLoad      <= 1'b1;
                pcLoadValue <= bootResetFuse ? bootSectionStart
                                             : cis_pkg::VEC_BASE_APP;
            end else if (acceptNow) begin
                pushReq  <= 1'b1;
                pushData <= pcIn;
            end else if (state_reg == cis_pkg::CIS_ENTRY && cnt_reg == cis_pkg::ONE_CYC) begin
                pcLoad      <= 1'b1;
                pcLoadValue <= vec_reg;
            end else if (state_reg == cis_pkg::CIS_RETURN && cnt_reg == cis_pkg::ONE_CYC) begin
                pcLoad      <= 1'b1;
                pcLoadValue <= popData;
            end
        end
    end

    // The vector's jump is an ordinary three-cycle instruction run by the core.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            coreHold       <= 1'b0;
            inHandlerEntry <= 1'b0;
            globalEnable   <= 1'b0;
            stackPtr       <= cis_pkg::SP_RST;
        end else begin
            coreHold       <= (state_reg != cis_pkg::CIS_RUN && cnt_reg > cis_pkg::ONE_CYC) ||
                              acceptNow || (state_reg == cis_pkg::CIS_RUN && returnFromIrqInstr);
            inHandlerEntry <= acceptNow ||
                              (state_reg == cis_pkg::CIS_ENTRY && cnt_reg > cis_pkg::ONE_CYC);
            globalEnable   <= status_reg[cis_pkg::GIE_BIT];
            stackPtr       <= sp_reg;
        end
    end

    // Read data one cycle after the strobe; unmapped reads give zero.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            regRdata <= '0;
        end else if (regRd) begin
            if (regAddr == cis_pkg::REG_STATUS) begin
                regRdata <= status_reg;
            end else if (regAddr == cis_pkg::REG_CTRL) begin
                regRdata <= ctrl_reg;
            end else if (regAddr == cis_pkg::REG_ENABLE) begin
                regRdata <= 8'(enable_reg);
            end else if (regAddr == cis_pkg::REG_FLAG) begin
                regRdata <= 8'(flag_reg);
            end else if (regAddr == cis_pkg::REG_SP_LO) begin
                regRdata <= sp_reg[7:0];
            end else if (regAddr == cis_pkg::REG_SP_HI) begin
                regRdata <= sp_reg[15:8];
            end else if (regAddr == cis_pkg::REG_LEVEL) begin
                regRdata <= 8'(levelSel_reg);
            end else if (regAddr == cis_pkg::REG_VEC_LO) begin
                regRdata <= vec_reg[7:0];
            end else if (regAddr == cis_pkg::REG_VEC_HI) begin
                regRdata <= vec_reg[15:8];
            end else begin
                regRdata <= '0;
            end
        end else begin
            regRdata <= '0;
        end
    end

    logic unusedWake;
    assign unusedWake = wakeEntry_reg ^ win_reg[0];
endmodule

// File: test/cis_checker_properties.sv
/*
 * Port-level checker for the interrupt sequencer: reset start, entry, return and blocking.
 * Assumes it is bound to every instance of cpu_interrupt_sequencer.
 */
`timescale 1ns/1ps
module cis_checker (
    // Clock and reset.
    input wire logic                     mclk,
    input wire logic                     rst,
    // Straps.
    input wire logic                     bootResetFuse,
    input wire logic [cis_pkg::PC_W-1:0] bootSectionStart,
    // Instruction sequencer inputs.
    input wire logic                     instrDone,
    input wire logic                     enableInstr,
    input wire logic                     disableInstr,
    input wire logic                     returnFromIrqInstr,
    input wire logic                     sleeping,
    input wire logic [cis_pkg::PC_W-1:0] pcIn,
    input wire logic [cis_pkg::PC_W-1:0] popData,
    // Sequencer outputs.
    input wire logic                     coreHold,
    input wire logic                     pcLoad,
    input wire logic [cis_pkg::PC_W-1:0] pcLoadValue,
    input wire logic                     pushReq,
    input wire logic [cis_pkg::PC_W-1:0] pushData,
    input wire logic [cis_pkg::SP_W-1:0] stackPtr,
    input wire logic                     globalEnable,
    input wire logic                     inHandlerEntry
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    a_reset_vector: assert property (
        $fell(rst) |=> pcLoad && pcLoadValue ==
            (bootResetFuse ? bootSectionStart : cis_pkg::VEC_BASE_APP))
        else $error("wrong start address after reset");
    a_entry_push: assert property (
        $rose(inHandlerEntry) |-> pushReq && coreHold && $past(instrDone))
        else $error("entry without push or boundary");
    a_entry_time: assert property (
        $rose(inHandlerEntry) && !$past(sleeping) |-> coreHold [*4] ##1 (pcLoad && !coreHold))
        else $error("entry length wrong");
    a_wake_time: assert property (
        $rose(inHandlerEntry) && $past(sleeping) |-> coreHold [*8] ##1 (pcLoad && !coreHold))
        else $error("wake entry length wrong");
    a_push_addr: assert property (
        pushReq |-> pushData == $past(pcIn))
        else $error("pushed address wrong");
    a_push_stack: assert property (
        pushReq |=> stackPtr == $past(stackPtr) - cis_pkg::SP_STEP_CALL)
        else $error("stack pointer not lowered by two");
    a_entry_gie: assert property (
        $rose(inHandlerEntry) |=> !globalEnable)
        else $error("global enable kept on entry");
    a_return_load: assert property (
        returnFromIrqInstr && !coreHold |-> ##[3:5] (pcLoad && pcLoadValue == popData))
        else $error("return address not loaded");
    a_return_gie: assert property (
        returnFromIrqInstr && !coreHold |-> ##[3:6] globalEnable)
        else $error("global enable not set by return");
    a_return_shadow: assert property (
        returnFromIrqInstr && !coreHold |-> !$rose(inHandlerEntry) [*6])
        else $error("entry too soon after return");
    a_disable_now: assert property (
        disableInstr |=> !$rose(inHandlerEntry) [*3])
        else $error("entry after disable");
    a_enable_shadow: assert property (
        enableInstr |=> !$rose(inHandlerEntry) [*2])
        else $error("entry before next instruction");
endmodule

bind cpu_interrupt_sequencer cis_checker chk_props (
    .mclk, .rst, .bootResetFuse, .bootSectionStart, .instrDone, .enableInstr,
    .disableInstr, .returnFromIrqInstr, .sleeping, .pcIn, .popData, .coreHold,
    .pcLoad, .pcLoadValue, .pushReq, .pushData, .stackPtr, .globalEnable, .inHandlerEntry
);

// File: test/cis_core_model.sv
/*
 * Behavioural model of the instruction sequencer and stack next to the interrupt sequencer.
 * Assumes the design's sequencer outputs and a slow-mode select from the bench.
 */
`timescale 1ns/1ps
module cis_core_model (
    // Clock and reset.
    input  wire logic                     mclk,
    input  wire logic                     rst,
    // Sequencer outputs of the design.
    input  wire logic                     coreHold,
    input  wire logic                     pcLoad,
    input  wire logic [cis_pkg::PC_W-1:0] pcLoadValue,
    input  wire logic                     pushReq,
    input  wire logic [cis_pkg::PC_W-1:0] pushData,
    // Bench control.
    input  wire logic                     slow,
    // Core outputs.
    output logic                          instrDone,
    output logic [cis_pkg::PC_W-1:0]      pcIn,
    output logic [cis_pkg::PC_W-1:0]      popData
);
    logic [1:0] phase_reg;

    // In slow mode each instruction takes three cycles and reports only its first one, at phase 0.
    assign instrDone = !rst && !coreHold && phase_reg == 2'h0;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            phase_reg <= 2'h0;
            pcIn      <= '0;
        end else begin
            phase_reg <= (slow && phase_reg != 2'h2) ? phase_reg + 2'h1 : 2'h0;
            if (pcLoad)
                pcIn <= pcLoadValue;
            else if (instrDone)
                pcIn <= pcIn + 16'h0001;
        end
    end

    // One return address is kept, enough for handlers that do not nest.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst)
            popData <= '0;
        else if (pushReq)
            popData <= pushData;
    end
endmodule

// File: test/test_cpu_interrupt_sequencer.sv
/*
 * Self-checking bench for the interrupt sequencer: registers, priority service, relocation,
 * level sources, lock and disable blocking. Assumes cis_pkg and the core model.
 */
`timescale 1ns/1ps
module test_cpu_interrupt_sequencer;
    logic        mclk, rst, fuse, appLock, sleeping, slow, regWr, regRd;
    logic        enableInstr, disableInstr, returnFromIrqInstr;
    logic        instrDone, coreHold, pcLoad, pushReq, globalEnable, inHandlerEntry;
    logic [3:0]  regAddr;
    logic [7:0]  srcEvent, srcLevel, regWdata, regRdata, pend, mask, c, d;
    logic [15:0] pcIn, popData, pcLoadValue, pushData, stackPtr, v, e;
    int          miscompares, comparisons, entries, n0;

    cpu_interrupt_sequencer dut (
        .mclk, .rst, .bootResetFuse(fuse), .appSectionLockBit(appLock),
        .bootSectionLockBit(1'b0), .bootSectionStart(cis_pkg::VEC_BASE_BOOT),
        .srcEvent, .srcLevel, .instrDone, .enableInstr, .disableInstr,
        .returnFromIrqInstr, .sleeping, .pcIn, .popData, .regAddr, .regWdata,
        .regWr, .regRd, .regRdata, .coreHold, .pcLoad, .pcLoadValue, .pushReq,
        .pushData, .stackPtr, .globalEnable, .inHandlerEntry
    );
    cis_core_model m (
        .mclk, .rst, .coreHold, .pcLoad, .pcLoadValue, .pushReq, .pushData,
        .slow, .instrDone, .pcIn, .popData
    );

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    always @(posedge inHandlerEntry) entries++;

    task automatic give_verdict();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk16(logic [15:0] got, logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk8(logic [7:0] got, logic [7:0] exp);
        chk16({8'h00, got}, {8'h00, exp});
    endtask
    task automatic wr(logic [3:0] a, logic [7:0] w);
        @(posedge mclk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= w;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask
    task automatic rd(logic [3:0] a, output logic [7:0] r);
        @(posedge mclk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRd <= 1'b0;
        #1 r = regRdata;
    endtask
    // Kind 0 enables, 1 disables, 2 returns from a handler.
    task automatic instr(int k);
        @(posedge mclk);
        enableInstr <= (k == 0);
        disableInstr <= (k == 1);
        returnFromIrqInstr <= (k == 2);
        @(posedge mclk);
        {enableInstr, disableInstr, returnFromIrqInstr} <= 3'h0;
    endtask
    task automatic wait_vec(output logic [15:0] r);
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            #1 n++;
        end while (pcLoad !== 1'b1 && n < 60);
        if (pcLoad !== 1'b1)
            miscompares++;
        r = pcLoadValue;
    endtask
    function automatic int low(logic [7:0] b);
        low = 0;
        for (int i = 7; i >= 0; i--)
            if (b[i])
                low = i;
    endfunction
    function automatic logic [15:0] vec(logic boot, int idx);
        return (boot ? cis_pkg::VEC_BASE_BOOT : cis_pkg::VEC_BASE_APP)
            + 16'(cis_pkg::VEC_SPACING * (idx + 1));
    endfunction

    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        give_verdict();
    end

    initial begin
        rst = 1'b1;
        {fuse, appLock, sleeping, slow, enableInstr, disableInstr, returnFromIrqInstr} = 7'h00;
        {regWr, regRd, regAddr, regWdata, srcEvent, srcLevel} = 30'h0;
        {miscompares, comparisons, entries} = 96'h0;
        void'($urandom(32'hb6e48b99));
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        repeat (3) @(posedge mclk);
        rd(cis_pkg::REG_STATUS, d);
        chk8(d, cis_pkg::STATUS_RST);
        rd(cis_pkg::REG_SP_HI, d);
        chk8(d, cis_pkg::SP_RST[15:8]);
        rd(4'hf, d);
        chk8(d, 8'h00);
        wr(cis_pkg::REG_STATUS, 8'h2a);
        for (int pass = 0; pass < 4; pass++) begin
            pend = (pass == 0) ? 8'hff : 8'($urandom);
            mask = (pass == 0) ? 8'hff : 8'($urandom);
            c = 8'($urandom);
            slow <= pass[0];
            wr(cis_pkg::REG_CTRL, pass[1] ? 8'h02 : 8'h00);
            wr(cis_pkg::REG_ENABLE, mask);
            @(posedge mclk);
            srcEvent <= pend;
            @(posedge mclk);
            srcEvent <= 8'h00;
            rd(cis_pkg::REG_FLAG, d);
            chk8(d, pend);
            wr(cis_pkg::REG_FLAG, c);
            pend = pend & ~c;
            rd(cis_pkg::REG_FLAG, d);
            chk8(d, pend);
            sleeping <= (pass == 3);
            instr(0);
            while ((pend & mask) != 8'h00) begin
                wait_vec(v);
                chk16(v, vec(pass[1], low(pend & mask)));
                pend[low(pend & mask)] = 1'b0;
                e = popData;
                rd(cis_pkg::REG_FLAG, d);
                chk8(d, pend);
                rd(cis_pkg::REG_STATUS, d);
                chk8(d, 8'h2a);
                instr(2);
                wait_vec(v);
                chk16(v, e);
            end
            sleeping <= 1'b0;
            repeat (10) @(posedge mclk);
            rd(cis_pkg::REG_FLAG, d);
            chk8(d, pend);
            rd(cis_pkg::REG_SP_LO, d);
            chk8(d, cis_pkg::SP_RST[7:0]);
            rd(cis_pkg::REG_STATUS, d);
            chk8(d, 8'haa);
            instr(1);
            wr(cis_pkg::REG_FLAG, 8'hff);
        end
        slow <= 1'b0;
        wr(cis_pkg::REG_LEVEL, 8'h80);
        wr(cis_pkg::REG_ENABLE, 8'h80);
        n0 = entries;
        srcLevel <= 8'h80;
        repeat (3) @(posedge mclk);
        srcLevel <= 8'h00;
        instr(0);
        repeat (10) @(posedge mclk);
        chk16(16'(entries - n0), 16'h0000);
        @(posedge mclk);
        srcLevel <= 8'h80;
        disableInstr <= 1'b1;
        @(posedge mclk);
        srcLevel <= 8'h00;
        disableInstr <= 1'b0;
        repeat (10) @(posedge mclk);
        chk16(16'(entries - n0), 16'h0000);
        appLock <= 1'b1;
        srcLevel <= 8'h80;
        instr(0);
        repeat (10) @(posedge mclk);
        chk16(16'(entries - n0), 16'h0000);
        appLock <= 1'b0;
        wait_vec(v);
        srcLevel <= 8'h00;
        chk16(v, vec(1'b1, 7));
        e = popData;
        rd(cis_pkg::REG_VEC_LO, d);
        chk8(d, 8'(vec(1'b1, 7)));
        instr(2);
        wait_vec(v);
        chk16(v, e);
        @(posedge mclk);
        fuse <= 1'b1;
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        #1 chk16(pcLoadValue, cis_pkg::VEC_BASE_BOOT);
        give_verdict();
    end
endmodule
